// File: rcr_host_model.sv
// Host controller model driving the register strobe port of the control registers
`timescale 1ns/1ns
`default_nettype none
module rcr_host_model (
   // Clock
   input  wire logic i_clk,
   // Register port towards the device
   output logic       o_wr_en,
   output logic       o_rd_en,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   // Idle bus; every change happens on the falling edge, away from the sampling edge
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 8'h00;
      o_wdata = 8'h00;
   end

   // One-cycle write pulse; released data is inverted so no stale value lingers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr_en = 1'b1;
      o_addr  = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr_en = 1'b0;
      o_wdata = ~d;
   endtask

   // One-cycle read pulse; the answer is collected by the bench monitor
   task automatic rd(input logic [7:0] a);
      @(negedge i_clk);
      o_rd_en = 1'b1;
      o_addr  = a;
      @(negedge i_clk);
      o_rd_en = 1'b0;
      o_addr  = ~a;
   endtask
endmodule
`default_nettype wire

// File: rcr_pkg.sv
// Constants shared by the regulator control register block
package rcr_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RAMP2_OFS = 8'h2B;
   localparam logic [7:0] BFUNC_OFS = 8'h38;
   localparam logic [7:0] LDO1_OFS  = 8'h39;
   localparam logic [7:0] LDO2_OFS  = 8'h3A;

   // ----------------------------------------------------------------
   // Field positions and read masks
   // ----------------------------------------------------------------
   localparam int         BYPASS_BIT = 4;
   localparam int         PGDLY_LSB  = 2;
   localparam int         MODSEL_BIT = 1;
   localparam int         SSEN_BIT   = 0;
   localparam logic [7:0] RAMP2_MASK = 8'h0F;
   localparam logic [7:0] BFUNC_MASK = 8'h1F;
   localparam logic [7:0] LDO_MASK   = 8'h1F;
   localparam logic [7:0] RSVD_READ  = 8'h00;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] RAMP2_RST  = 4'h8;
   localparam logic [1:0] PGDLY_RST  = 2'h1;
   localparam logic       MODSEL_RST = 1'b1;
   localparam logic       SSEN_RST   = 1'b0;

   // ----------------------------------------------------------------
   // Ramp and linear regulator decode
   // ----------------------------------------------------------------
   localparam logic [3:0]  RAMP_INSTANT = 4'h0;
   localparam logic [3:0]  RAMP_MAX     = 4'hA;
   localparam logic [4:0]  LDO_TOP_CODE = 5'h19;
   localparam logic [11:0] LDO_BASE_MV  = 12'h3E8;  // 1.0 V
   localparam logic [11:0] LDO_STEP_MV  = 12'h064;  // 0.1 V
   localparam logic [11:0] LDO_FIXED_MV = 12'hB22;  // 2.85 V

   // ----------------------------------------------------------------
   // Timing: figures in their own units, counts derived from the clock
   // ----------------------------------------------------------------
   localparam int CLK_KHZ     = 100000;
   localparam int CLK_MHZ     = CLK_KHZ / 1000;
   localparam int SS_FAST_KHZ = 10;
   localparam int SS_SLOW_KHZ = 2;
   localparam int SS_FAST_HALF_CYC = CLK_KHZ / (2 * SS_FAST_KHZ);
   localparam int SS_SLOW_HALF_CYC = CLK_KHZ / (2 * SS_SLOW_KHZ);
   localparam int PG_T0_US  = 50;
   localparam int PG_T1_MS  = 50;
   localparam int PG_T2_MS  = 100;
   localparam int PG_T3_MS  = 200;
   localparam int PG_T0_CYC = PG_T0_US * CLK_MHZ;
   localparam int PG_T1_CYC = PG_T1_MS * CLK_KHZ;
   localparam int PG_T2_CYC = PG_T2_MS * CLK_KHZ;
   localparam int PG_T3_CYC = PG_T3_MS * CLK_KHZ;
   localparam int CNT_W     = 25;
endpackage

// File: rcr_regs.sv
// Regulator control registers: ramp, buck function and linear regulator levels
//
// Contract
// R1: Ramp code 0 instant, 1-10 mV/us, above clamps 10
// R2: Spread spectrum sweeps around centre at selected rate
// R3: Modulation select 0 is 10 kHz, 1 is 2 kHz
// R4: Delay field picks 50us/50ms/100ms/200ms, resets 01
// R5: Power good low only after delay in regulation
// R6: Undervoltage disables all four regulators
// R7: Bypass bit set ignores the undervoltage condition
// R8: First linear code: 1.0 V plus 0.1 V steps
// R9: Second linear code maps identically, saturating 3.5 V
// R10: Fixed option holds both linear outputs 2.85 V
// R11: Reserved bits read zero, writes ignored
// R12: Spread enable bit switches modulation, resets off
`timescale 1ns/1ns
`default_nettype none
module rcr_regs
   import rcr_pkg::*;
#(
   parameter logic                  FIXED_LDO   = 1'b0,
   parameter logic                  BYPASS_RST  = 1'b0,
   parameter logic [4:0]            LDO1_RST    = 5'h08,
   parameter logic [4:0]            LDO2_RST    = 5'h08,
   parameter logic [rcr_pkg::CNT_W-1:0] SS_FAST_HALF = rcr_pkg::CNT_W'(rcr_pkg::SS_FAST_HALF_CYC),
   parameter logic [rcr_pkg::CNT_W-1:0] SS_SLOW_HALF = rcr_pkg::CNT_W'(rcr_pkg::SS_SLOW_HALF_CYC),
   parameter logic [rcr_pkg::CNT_W-1:0] PG_DLY0      = rcr_pkg::CNT_W'(rcr_pkg::PG_T0_CYC),
   parameter logic [rcr_pkg::CNT_W-1:0] PG_DLY1      = rcr_pkg::CNT_W'(rcr_pkg::PG_T1_CYC),
   parameter logic [rcr_pkg::CNT_W-1:0] PG_DLY2      = rcr_pkg::CNT_W'(rcr_pkg::PG_T2_CYC),
   parameter logic [rcr_pkg::CNT_W-1:0] PG_DLY3      = rcr_pkg::CNT_W'(rcr_pkg::PG_T3_CYC)
) (
   // Clock and reset
   input  wire logic                      I_CORE_CLK,
   input  wire logic                      I_RST_N,
   // Register port from the serial interface logic
   input  wire logic                      I_WR_EN,
   input  wire logic                      I_RD_EN,
   input  wire logic [7:0]                I_ADDR,
   input  wire logic [7:0]                I_WDATA,
   output logic [7:0]                     O_RDATA,
   output logic                           O_RD_VALID,
   // Analog status inputs
   input  wire logic                      I_BUCK1_IN_REG,
   input  wire logic                      I_BUCK2_IN_REG,
   input  wire logic                      I_RAW_INPUT_SUPPLY_LOW,
   // Buck controls
   output logic [3:0]                     O_SECOND_RAMP_RATE,
   output logic                           O_SECOND_RAMP_INSTANT,
   output logic                           O_SS_ACTIVE,
   output logic                           O_SS_RISING,
   output logic [rcr_pkg::CNT_W-1:0]      O_SS_PHASE,
   // Regulator enables and power good
   output logic [3:0]                     O_REG_EN,
   output logic                           O_POWER_GOOD_N,
   // Linear regulator levels in millivolts
   output logic [11:0]                    O_FIRST_LINEAR_MV,
   output logic [11:0]                    O_SECOND_LINEAR_MV
);
   import rcr_pkg::*;

   // ----------------------------------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------------------------------
   logic              rst_s1_q;
   logic              rst_n;
   logic              b1_ok_s;
   logic              b2_ok_s;
   logic              uv_low_s;
   logic [3:0]        second_ramp_select_q;
   logic              lockout_bypass_q;
   logic [1:0]        power_good_delay_sel_q;
   logic              modulation_rate_sel_q;
   logic              spread_enable_q;
   logic [4:0]        first_linear_level_q;
   logic [4:0]        second_linear_level_q;
   logic [CNT_W-1:0]  pg_cnt_q;
   logic [CNT_W-1:0]  pg_target;
   logic              pg_q;
   logic              in_reg;
   logic              lockout;

   // Release is synchronous so no flop leaves reset on a ragged edge
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // Status pins come from the analog side, asynchronous to the register clock
   rcr_sync2 u_sync_b1 (.i_clk(I_CORE_CLK), .i_rst_n(rst_n), .i_d(I_BUCK1_IN_REG), .o_q(b1_ok_s));
   rcr_sync2 u_sync_b2 (.i_clk(I_CORE_CLK), .i_rst_n(rst_n), .i_d(I_BUCK2_IN_REG), .o_q(b2_ok_s));
   rcr_sync2 u_sync_uv (.i_clk(I_CORE_CLK), .i_rst_n(rst_n), .i_d(I_RAW_INPUT_SUPPLY_LOW), .o_q(uv_low_s));

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Only the implemented field bits are stored; the rest are dropped
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         second_ramp_select_q   <= RAMP2_RST;
         lockout_bypass_q       <= BYPASS_RST;
         power_good_delay_sel_q <= PGDLY_RST;   // [R4]
         modulation_rate_sel_q  <= MODSEL_RST;  // [R3]
         spread_enable_q        <= SSEN_RST;    // [R12]
         first_linear_level_q   <= LDO1_RST;
         second_linear_level_q  <= LDO2_RST;
      end else if (I_WR_EN) begin
         case (I_ADDR)
            RAMP2_OFS: begin
               second_ramp_select_q <= I_WDATA[3:0];  // [R11]
            end
            BFUNC_OFS: begin
               lockout_bypass_q       <= I_WDATA[BYPASS_BIT];
               power_good_delay_sel_q <= I_WDATA[PGDLY_LSB +: 2];
               modulation_rate_sel_q  <= I_WDATA[MODSEL_BIT];
               spread_enable_q        <= I_WDATA[SSEN_BIT];
            end
            LDO1_OFS: begin
               first_linear_level_q <= I_WDATA[4:0];
            end
            LDO2_OFS: begin
               second_linear_level_q <= I_WDATA[4:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // Read data is registered; unmapped offsets return zero
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_RDATA    <= RSVD_READ;
         O_RD_VALID <= 1'b0;
      end else begin
         O_RD_VALID <= I_RD_EN;
         if (I_RD_EN) begin
            case (I_ADDR)
               RAMP2_OFS: O_RDATA <= {4'h0, second_ramp_select_q} & RAMP2_MASK;  // [R11]
               BFUNC_OFS: O_RDATA <= {3'h0, lockout_bypass_q, power_good_delay_sel_q,
                                      modulation_rate_sel_q, spread_enable_q} & BFUNC_MASK;
               LDO1_OFS:  O_RDATA <= {3'h0, first_linear_level_q} & LDO_MASK;
               LDO2_OFS:  O_RDATA <= {3'h0, second_linear_level_q} & LDO_MASK;
               default:   O_RDATA <= RSVD_READ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Ramp decode for the second converter
   // ----------------------------------------------------------------
   // Codes above ten share the fastest rate
   assign O_SECOND_RAMP_RATE    = (second_ramp_select_q > RAMP_MAX) ? RAMP_MAX : second_ramp_select_q;  // [R1]
   assign O_SECOND_RAMP_INSTANT = (second_ramp_select_q == RAMP_INSTANT);                              // [R1]

   // ----------------------------------------------------------------
   // Spread spectrum sweep
   // ----------------------------------------------------------------
   // Half period length sets the sweep rate; disabled means fixed frequency
   rcr_tri_gen #(.CW(CNT_W)) u_tri (
      .i_clk    (I_CORE_CLK),
      .i_rst_n  (rst_n),
      .i_en     (spread_enable_q),                                        // [R12]
      .i_half   (modulation_rate_sel_q ? SS_SLOW_HALF : SS_FAST_HALF),   // [R2] [R3]
      .o_rising (O_SS_RISING),
      .o_phase  (O_SS_PHASE)
   );
   assign O_SS_ACTIVE = spread_enable_q;  // [R12]

   // ----------------------------------------------------------------
   // Undervoltage lockout
   // ----------------------------------------------------------------
   assign lockout  = uv_low_s & ~lockout_bypass_q;  // [R6] [R7]
   assign O_REG_EN = lockout ? 4'h0 : 4'hF;         // [R6]

   // ----------------------------------------------------------------
   // Power good delay
   // ----------------------------------------------------------------
   always_comb begin
      case (power_good_delay_sel_q)
         2'h0:    pg_target = PG_DLY0;  // [R4]
         2'h1:    pg_target = PG_DLY1;
         2'h2:    pg_target = PG_DLY2;
         default: pg_target = PG_DLY3;
      endcase
   end
   // Both converters must be in regulation with the lockout clear
   assign in_reg = b1_ok_s & b2_ok_s & ~lockout;

   // Any drop out of regulation restarts the whole delay
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pg_cnt_q <= '0;
         pg_q     <= 1'b0;
      end else if (!in_reg) begin
         pg_cnt_q <= '0;
         pg_q     <= 1'b0;                 // [R5]
      end else if (pg_cnt_q >= pg_target - CNT_W'(1)) begin
         pg_q     <= 1'b1;                 // [R5]
      end else begin
         pg_cnt_q <= pg_cnt_q + CNT_W'(1);
      end
   end
   assign O_POWER_GOOD_N = ~pg_q;

   // ----------------------------------------------------------------
   // Linear regulator levels
   // ----------------------------------------------------------------
   // Fixed option ignores the stored codes, which stay readable
   function automatic logic [11:0] ldo_mv(input logic [4:0] code);
      logic [4:0] sat;
      sat    = (code > LDO_TOP_CODE) ? LDO_TOP_CODE : code;
      ldo_mv = LDO_BASE_MV + 12'(sat) * LDO_STEP_MV;
   endfunction

   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_FIRST_LINEAR_MV  <= LDO_BASE_MV;
         O_SECOND_LINEAR_MV <= LDO_BASE_MV;
      end else begin
         O_FIRST_LINEAR_MV  <= FIXED_LDO ? LDO_FIXED_MV : ldo_mv(first_linear_level_q);   // [R8] [R10]
         O_SECOND_LINEAR_MV <= FIXED_LDO ? LDO_FIXED_MV : ldo_mv(second_linear_level_q);  // [R9] [R10]
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Ramp decode: clamp above ten, pass the code through below
   a_ramp_clamp: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R1]
      (second_ramp_select_q > RAMP_MAX) |-> (O_SECOND_RAMP_RATE == 4'hA))
      else $error("ramp code above ten not clamped");
   a_ramp_pass: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R1]
      (second_ramp_select_q <= RAMP_MAX) |-> (O_SECOND_RAMP_RATE == second_ramp_select_q))
      else $error("ramp code not passed through");

   // Lockout and power good
   a_uvlo_gate: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R6]
      (uv_low_s && !lockout_bypass_q) |-> (O_REG_EN == 4'h0) ##1 !pg_q)
      else $error("regulators not disabled under lockout");
   a_uvlo_bypass: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R7]
      lockout_bypass_q |-> (O_REG_EN == 4'hF))
      else $error("lockout not bypassed");
   a_pg_drop: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R5]
      !(b1_ok_s && b2_ok_s) |=> O_POWER_GOOD_N)
      else $error("power good asserted out of regulation");
   a_pg_delay: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R4]
      $rose(pg_q) |-> ($past(pg_cnt_q) >= pg_target - CNT_W'(1)) && $past(in_reg))
      else $error("power good released before delay");
   a_pg_lock: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R6]
      lockout |=> O_POWER_GOOD_N)
      else $error("power good asserted under lockout");

   // Linear regulator levels
   a_ldo1_map: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R8]
      (!FIXED_LDO && first_linear_level_q == 5'h1F) |=> (O_FIRST_LINEAR_MV == 12'hDAC))
      else $error("first linear level not saturated");
   a_ldo2_map: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R9]
      (!FIXED_LDO && second_linear_level_q == 5'h00) |=> (O_SECOND_LINEAR_MV == 12'h3E8))
      else $error("second linear base level wrong");
   a_ldo1_top: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R8]
      (!FIXED_LDO && first_linear_level_q == LDO_TOP_CODE) |=> (O_FIRST_LINEAR_MV == 12'hDAC))
      else $error("first linear top level wrong");
   a_ldo2_sat: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R9]
      (!FIXED_LDO && second_linear_level_q == 5'h1A) |=> (O_SECOND_LINEAR_MV == 12'hDAC))
      else $error("second linear level not saturated");
   a_ldo_fixed: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R10]
      FIXED_LDO |=> (O_FIRST_LINEAR_MV == 12'hB22) && (O_SECOND_LINEAR_MV == 12'hB22))
      else $error("fixed option level wrong");

   // Register read port
   a_rd_pulse: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R11]
      I_RD_EN |=> O_RD_VALID)
      else $error("read answer missing");
   a_rd_unmapped: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R11]
      (I_RD_EN && (I_ADDR > LDO2_OFS)) |=> (O_RDATA == RSVD_READ))
      else $error("unmapped read nonzero");
   a_rsvd_zero: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R11]
      (I_RD_EN && I_ADDR == BFUNC_OFS) |=> (O_RDATA[7:5] == 3'h0) && O_RD_VALID)
      else $error("reserved bits read nonzero");

   // Spread spectrum sweep; a rate change gets one cycle to fold the phase back
   a_ss_fixed: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R12]
      !spread_enable_q |=> (O_SS_PHASE == '0) && O_SS_RISING)
      else $error("sweep running while disabled");
   a_ss_turn: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R2]
      (spread_enable_q && $changed(O_SS_RISING)) |-> ($past(O_SS_PHASE) >=
         (modulation_rate_sel_q ? SS_SLOW_HALF : SS_FAST_HALF) - CNT_W'(1)))
      else $error("sweep turned early");
   a_ss_rate: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R3]
      (spread_enable_q && !modulation_rate_sel_q && !$past(modulation_rate_sel_q)) |->
         (O_SS_PHASE < SS_FAST_HALF))
      else $error("fast sweep exceeded half period");
   a_ss_slow: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)  // [R3]
      (spread_enable_q && modulation_rate_sel_q) |-> (O_SS_PHASE < SS_SLOW_HALF))
      else $error("slow sweep exceeded half period");
endmodule
`default_nettype wire

// File: rcr_sync2.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module rcr_sync2 (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Level in and out
   input  wire logic i_d,
   output logic      o_q
);
   logic meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         o_q    <= 1'b0;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule
`default_nettype wire

// File: rcr_tri_gen.sv
// Triangular modulation sweep generator for spread spectrum
`timescale 1ns/1ns
`default_nettype none
module rcr_tri_gen #(
   parameter int CW = 25
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst_n,
   // Control
   input  wire logic          i_en,
   input  wire logic [CW-1:0] i_half,
   // Sweep state
   output logic               o_rising,
   output logic [CW-1:0]      o_phase
);
   // Phase walks up for one half period, then direction flips
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_phase  <= '0;
         o_rising <= 1'b1;
      end else if (!i_en) begin
         o_phase  <= '0;
         o_rising <= 1'b1;
      end else if (o_phase >= i_half - CW'(1)) begin
         o_phase  <= '0;
         o_rising <= ~o_rising;
      end else begin
         o_phase  <= o_phase + CW'(1);
      end
   end
endmodule
`default_nettype wire

// File: regulator_control_registers_tb.sv
// Self-checking bench for the regulator control register block
`timescale 1ns/1ns
`default_nettype none
module regulator_control_registers_tb;
   import rcr_pkg::*;
   logic              clk, rst_n, bk1, bk2, uv;
   logic              wr_en, rd_en, rd_valid, inst, ss_act, ss_rise, pg_n;
   logic [7:0]        addr, wdata, rdata, v;
   logic [3:0]        ramp, reg_en;
   logic [CNT_W-1:0]  ss_ph;
   logic [11:0]       mv1, mv2;
   logic [7:0]        exp_q[$];
   int                n_fail, checks;

   // Short delay and sweep counts keep the run brief
   // The shortest power-good delay keeps its real count from the package
   rcr_regs #(.SS_FAST_HALF(25'd5), .SS_SLOW_HALF(25'd25), .PG_DLY1(25'd20),
      .PG_DLY2(25'd30), .PG_DLY3(25'd40)) uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_WR_EN(wr_en),
      .I_RD_EN(rd_en), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_RD_VALID(rd_valid),
      .I_BUCK1_IN_REG(bk1), .I_BUCK2_IN_REG(bk2), .I_RAW_INPUT_SUPPLY_LOW(uv),
      .O_SECOND_RAMP_RATE(ramp), .O_SECOND_RAMP_INSTANT(inst), .O_SS_ACTIVE(ss_act),
      .O_SS_RISING(ss_rise), .O_SS_PHASE(ss_ph), .O_REG_EN(reg_en), .O_POWER_GOOD_N(pg_n),
      .O_FIRST_LINEAR_MV(mv1), .O_SECOND_LINEAR_MV(mv2));
   rcr_host_model host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic chk(input logic [11:0] g, input logic [11:0] e, input string m);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Read request with its expected byte noted first
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask

   // Read answers are settled by the falling edge after the valid pulse rises
   always @(negedge clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) chk(12'h001, 12'h000, "unexpected read");
         else chk({4'h0, rdata}, {4'h0, exp_q.pop_front()}, "read data");
      end
   end

   // Power-good release must land inside a small window after the programmed count
   task automatic pg_run(input logic [1:0] sel, input int d);
      int n;
      host.wr(BFUNC_OFS, {3'($urandom), 1'b0, sel, 2'b10});
      rdx(BFUNC_OFS, {4'h0, sel, 2'b10});
      @(negedge clk);
      bk1 = 1'b1;
      bk2 = 1'b1;
      n = 0;
      while (pg_n !== 1'b0 && n < d + 10) begin
         @(negedge clk);
         n++;
      end
      chk(12'(n > d && n <= d + 5), 12'h001, "power good delay");
      bk2 = 1'b0;
      repeat (4) @(negedge clk);
      chk(pg_n, 1'b1, "power good drop");
      bk1 = 1'b0;
   endtask

   // Sweep direction must hold for exactly the selected half period
   task automatic ss_run(input logic sel, input int half);
      int  k;
      logic p;
      host.wr(BFUNC_OFS, {4'h1, sel, 1'b1});
      chk(ss_act, 1'b1, "spread active");
      for (int i = 0; i < 2; i++) begin
         p = ss_rise;
         k = 0;
         while (ss_rise === p && k < 100) begin
            @(negedge clk);
            k++;
         end
      end
      chk(12'(k), 12'(half), "sweep half period");
   endtask

   // Watchdog sized well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      print_verdict();
   end

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      bk1 = 1'b0;
      bk2 = 1'b0;
      uv = 1'b0;
      void'($urandom(26));
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      // Reset state and an unmapped place
      chk(mv1, 12'd1800, "ldo1 reset level");
      chk(ss_act, 1'b0, "spread off at reset");
      chk(reg_en, 4'hF, "enables at reset");
      rdx(RAMP2_OFS, 8'h08);
      rdx(BFUNC_OFS, 8'h06);
      rdx(LDO1_OFS, 8'h08);
      host.wr(8'h3B, 8'hFF);
      rdx(8'h3B, 8'h00);
      // Every ramp code, with junk in the reserved bits
      for (int c = 0; c < 16; c++) begin
         v = 8'($urandom);
         v[3:0] = c[3:0];
         host.wr(RAMP2_OFS, v);
         rdx(RAMP2_OFS, {4'h0, c[3:0]});
         chk(ramp, 12'((c > 10) ? 10 : c), "ramp rate");
         chk(inst, 12'(c == 0), "ramp instant");
      end
      // Every linear code on both regulators, in opposite order
      for (int c = 0; c < 32; c++) begin
         v = 8'($urandom);
         host.wr(LDO1_OFS, {v[7:5], c[4:0]});
         host.wr(LDO2_OFS, {v[2:0], 5'(31 - c)});
         @(negedge clk);
         chk(mv1, 12'((c > 25) ? 3500 : 1000 + 100 * c), "ldo1 level");
         chk(mv2, 12'((31 - c > 25) ? 3500 : 1000 + 100 * (31 - c)), "ldo2 level");
         rdx(LDO1_OFS, {3'h0, c[4:0]});
      end
      // Spread spectrum at both rates, then off again
      ss_run(1'b0, 5);
      ss_run(1'b1, 25);
      // Power-good delay for each selector code
      pg_run(2'h0, PG_T0_CYC);
      pg_run(2'h1, 20);
      pg_run(2'h2, 30);
      pg_run(2'h3, 40);
      chk(ss_act, 1'b0, "spread off");
      // Undervoltage lockout, honoured then bypassed
      uv = 1'b1;
      bk1 = 1'b1;
      bk2 = 1'b1;
      repeat (4) @(negedge clk);
      chk(reg_en, 4'h0, "lockout disables");
      repeat (60) @(negedge clk);
      chk(pg_n, 1'b1, "lockout holds power good off");
      host.wr(BFUNC_OFS, 8'h1E);
      @(negedge clk);
      chk(reg_en, 4'hF, "bypass ignores lockout");
      rdx(BFUNC_OFS, 8'h1E);
      uv = 1'b0;
      repeat (4) @(negedge clk);
      chk(12'(exp_q.size()), 12'h000, "reads answered");
      print_verdict();
   end
endmodule
`default_nettype wire
